/* File: design/rsc_serial_cmd.sv */
// Serial command front end of the base-station reader
//
// Overview of operation
// - Filter select low: pin levels reach the logic unfiltered.
// - Filter select high: pins sampled once per carrier period.
// - Filtered level changes only after two equal successive samples.
// - Filtered deep sleep: clock low, data-in unlike disable bit wakes.
// - Leading bits 111 enter receive passthrough, data on data-out.
// - Serial clock rising edge ends receive passthrough.
// - Opcode 0001 stores pulse width nibble, enters write mode.
// - Zero pulse width: data-in high drivers off, low drivers on.
// - Nonzero width: data-in rise gives off pulse of width units.
// - Serial clock rise ends write mode, drivers restore at once.
// - Bits 110 enter write mode right after the third bit.
// - Short write reuses last pulse width, zero if none.
// - Phase query returns two zeros and six-bit phase.
// - Top bits 10 store six-bit sample delay, no answer.
// - Page read answers with selected page in low nibble.
// - Top bits 01 write four bits into the selected page.
// - Upper answer nibble: pulse width for pages 0-1, status else.
// - Sample delay read returns stored delay with two zeros.
// - Data-in rise while serial clock high starts a new command.
// - MSB first; data-in taken at clock rise, data-out in high phase.
`timescale 1ns/1ns
`default_nettype none
module rsc_serial_cmd
    import rsc_pkg::*;
(
    // System clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Carrier clock for the pin filter
    input  wire logic       car_clk,
    // Host pins
    input  wire logic       sclk_pin,
    input  wire logic       din_pin,
    output logic            dout_o,
    output logic            dout_oe,
    // Filter select strap
    input  wire logic       filt_sel,
    // Receiver side
    input  wire logic       rx_data,
    input  wire logic [5:0] phase_val,
    input  wire logic [3:0] status_nibble,
    // Antenna driver and configuration
    output logic            drv_on,
    output logic [3:0]      pulse_width,
    output logic [5:0]      sample_delay,
    output logic [3:0]      cfg_page0,
    output logic [3:0]      cfg_page1,
    output logic [3:0]      cfg_page2,
    output logic [3:0]      cfg_page3
);
    // Width times unit less one, cut to the counter width
    function automatic logic [PULSE_CNT_W-1:0] pulse_len(
        input logic [3:0] n
    );
        pulse_len = PULSE_CNT_W'(int'(n) * PULSE_UNIT_CYC - 1);
    endfunction : pulse_len
    // Page read answer
    function automatic logic [7:0] page_answer(
        input logic [1:0] pg,
        input logic [3:0] pw,
        input logic [3:0] stat,
        input logic [3:0] data
    );
        page_answer = pg[1] ? {stat, data} : {pw, data};
    endfunction : page_answer
    logic [1:0] raw_s1_ff;
    logic [1:0] raw_s2_ff;
    logic [1:0] flt_s1_ff;
    logic [1:0] flt_s2_ff;
    logic       fsel_s1_ff;
    logic       fsel_s2_ff;
    logic [1:0] pin_flt;
    // Carrier-domain filter
    rsc_pin_filter u_filter (
        .car_clk (car_clk),
        .rst     (rst),
        .pin_raw ({sclk_pin, din_pin}),
        .pin_flt (pin_flt)
    );
    // Two-stage synchronisers into the system clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            raw_s1_ff  <= 2'h0;
            raw_s2_ff  <= 2'h0;
            flt_s1_ff  <= 2'h0;
            flt_s2_ff  <= 2'h0;
            fsel_s1_ff <= 1'b0;
            fsel_s2_ff <= 1'b0;
        end else begin
            raw_s1_ff  <= {sclk_pin, din_pin};
            raw_s2_ff  <= raw_s1_ff;
            flt_s1_ff  <= pin_flt;
            flt_s2_ff  <= flt_s1_ff;
            fsel_s1_ff <= filt_sel;
            fsel_s2_ff <= fsel_s1_ff;
        end
    end

    // Internal pin levels, filtered or straight
    logic sclk_i;
    logic din_i;
    assign sclk_i = fsel_s2_ff ? flt_s2_ff[1] : raw_s2_ff[1];
    assign din_i  = fsel_s2_ff ? flt_s2_ff[0] : raw_s2_ff[0];
    rsc_state_t             state_ff,   nxt_state;
    logic                   sclk_q_ff,  nxt_sclk_q;
    logic                   din_q_ff,   nxt_din_q;
    logic [7:0]             shreg_ff,   nxt_shreg;
    logic [3:0]             cnt_ff,     nxt_cnt;
    logic [7:0]             resp_ff,    nxt_resp;
    logic [3:0]             pw_ff,      nxt_pw;
    logic [5:0]             delay_ff,   nxt_delay;
    logic [3:0]             page_ff     [4];
    logic [3:0]             nxt_page    [4];
    logic [PULSE_CNT_W-1:0] pcnt_ff,    nxt_pcnt;
    logic                   drv_on_ff,  nxt_drv_on;
    logic                   dout_oe_ff, nxt_dout_oe;
    logic       sclk_rise;
    logic       din_rise;
    logic       init_seen;
    logic [7:0] bits;
    logic       driver_disable_bit;

    assign sclk_rise = sclk_i & ~sclk_q_ff;
    assign din_rise  = din_i & ~din_q_ff;
    assign init_seen = din_rise & sclk_i & sclk_q_ff;
    assign bits      = {shreg_ff[6:0], din_i};
    assign driver_disable_bit     = page_ff[1][PG1_DRIVER_DISABLE_BIT_BIT];
    // Command decoder, answer shifter and write pulse timer
    always_comb begin
        nxt_state   = state_ff;
        nxt_sclk_q  = sclk_i;
        nxt_din_q   = din_i;
        nxt_shreg   = shreg_ff;
        nxt_cnt     = cnt_ff;
        nxt_resp    = resp_ff;
        nxt_pw      = pw_ff;
        nxt_delay   = delay_ff;
        nxt_page    = page_ff;
        nxt_pcnt    = '0;
        nxt_drv_on  = ~driver_disable_bit;
        nxt_dout_oe = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (init_seen) begin
                    nxt_state = ST_CMD;
                    nxt_cnt   = 4'h0;
                    nxt_shreg = 8'h00;
                end
            end
            ST_CMD: begin
                if (init_seen) begin
                    nxt_cnt   = 4'h0;
                    nxt_shreg = 8'h00;
                end else if (sclk_rise) begin
                    nxt_shreg = bits;
                    nxt_cnt   = cnt_ff + 4'h1;
                    if (cnt_ff == SHORT_LAST_BIT
                        && bits[2:0] == OP_RX_PASS) begin
                        nxt_state = ST_RX_PASS;
                    end else if (cnt_ff == SHORT_LAST_BIT
                        && bits[2:0] == OP_WR_SHORT) begin
                        nxt_state = ST_WRITE;
                    end else if (cnt_ff == CMD_LAST_BIT) begin
                        nxt_cnt   = 4'h0;
                        nxt_state = ST_IDLE;
                        if (bits[7:4] == OP_PW_WR_HI) begin
                            nxt_pw    = bits[3:0];
                            nxt_state = ST_WRITE;
                        end else if (bits[7:6] == OP_DELAY_WR) begin
                            nxt_delay = bits[5:0];
                        end else if (bits[7:6] == OP_PAGE_WR) begin
                            nxt_page[bits[5:4]] = bits[3:0];
                        end else if (bits == OP_DELAY_RD) begin
                            nxt_resp  = {2'h0, delay_ff};
                            nxt_state = ST_RESP;
                        end else if (bits == OP_PHASE_RD) begin
                            nxt_resp  = {2'h0, phase_val};
                            nxt_state = ST_RESP;
                        end else if (bits[7:2] == OP_PAGE_RD_HI) begin
                            nxt_resp  = page_answer(bits[1:0], pw_ff,
                                status_nibble, page_ff[bits[1:0]]);
                            nxt_state = ST_RESP;
                        end
                    end
                end
            end
            ST_RESP: begin
                nxt_dout_oe = dout_oe_ff;
                if (init_seen) begin
                    nxt_state   = ST_CMD;
                    nxt_cnt     = 4'h0;
                    nxt_shreg   = 8'h00;
                    nxt_dout_oe = 1'b0;
                end else if (sclk_rise) begin
                    if (cnt_ff == RESP_BITS) begin
                        nxt_state   = ST_IDLE;
                        nxt_cnt     = 4'h0;
                        nxt_dout_oe = 1'b0;
                    end else begin
                        nxt_dout_oe = ~resp_ff[7];
                        nxt_resp    = {resp_ff[6:0], 1'b0};
                        nxt_cnt     = cnt_ff + 4'h1;
                    end
                end
            end
            ST_RX_PASS: begin
                nxt_dout_oe = ~rx_data;
                if (sclk_rise) begin
                    nxt_state   = ST_IDLE;
                    nxt_cnt     = 4'h0;
                    nxt_dout_oe = 1'b0;
                end
            end
            ST_WRITE: begin
                if (sclk_rise) begin
                    nxt_state = ST_IDLE;
                    nxt_cnt   = 4'h0;
                end else if (pw_ff == 4'h0) begin
                    nxt_drv_on = ~din_i;
                end else if (pcnt_ff != '0) begin
                    nxt_pcnt   = pcnt_ff - PULSE_CNT_W'(1);
                    nxt_drv_on = 1'b0;
                end else if (din_rise) begin
                    nxt_pcnt   = pulse_len(pw_ff);
                    nxt_drv_on = 1'b0;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        // Wake from deep sleep through the raw pin levels
        if (fsel_s2_ff && page_ff[1][PG1_PD_BIT]
            && page_ff[1][PG1_DEEP_BIT] && !raw_s2_ff[1]
            && raw_s2_ff[0] != driver_disable_bit) begin
            nxt_page[1][PG1_DEEP_BIT] = 1'b0;
        end
    end
    // Decoder registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff   <= ST_IDLE;
            sclk_q_ff  <= 1'b0;
            din_q_ff   <= 1'b0;
            shreg_ff   <= 8'h00;
            cnt_ff     <= 4'h0;
            resp_ff    <= 8'h00;
            pw_ff      <= PW_RST;
            delay_ff   <= DELAY_RST;
            page_ff    <= '{PAGE0_RST, PAGE_RST, PAGE_RST, PAGE_RST};
            pcnt_ff    <= '0;
            drv_on_ff  <= 1'b1;
            dout_oe_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            sclk_q_ff  <= nxt_sclk_q;
            din_q_ff   <= nxt_din_q;
            shreg_ff   <= nxt_shreg;
            cnt_ff     <= nxt_cnt;
            resp_ff    <= nxt_resp;
            pw_ff      <= nxt_pw;
            delay_ff   <= nxt_delay;
            page_ff    <= nxt_page;
            pcnt_ff    <= nxt_pcnt;
            drv_on_ff  <= nxt_drv_on;
            dout_oe_ff <= nxt_dout_oe;
        end
    end

    // Outputs straight from flip-flops; data-out only ever pulls low
    assign dout_o       = 1'b0;
    assign dout_oe      = dout_oe_ff;
    assign drv_on       = drv_on_ff;
    assign pulse_width  = pw_ff;
    assign sample_delay = delay_ff;
    assign cfg_page0    = page_ff[0];
    assign cfg_page1    = page_ff[1];
    assign cfg_page2    = page_ff[2];
    assign cfg_page3    = page_ff[3];
    // Checks on the system clock
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    raw_path_a: assert property (
        !fsel_s2_ff |-> sclk_i == $past(sclk_pin, 2)
        && din_i == $past(din_pin, 2))
        else $error("unfiltered path does not follow pins");
    rx_enter_a: assert property (
        state_ff == ST_CMD && sclk_rise && !init_seen
        && cnt_ff == SHORT_LAST_BIT && bits[2:0] == OP_RX_PASS
        |=> state_ff == ST_RX_PASS ##1 dout_oe_ff == !$past(rx_data))
        else $error("receive passthrough not entered");
    rx_exit_a: assert property (
        state_ff == ST_RX_PASS && sclk_rise
        |=> state_ff == ST_IDLE && !dout_oe_ff)
        else $error("receive passthrough not left on clock rise");
    pw_load_a: assert property (
        state_ff == ST_CMD && sclk_rise && !init_seen
        && cnt_ff == CMD_LAST_BIT && bits[7:4] == OP_PW_WR_HI
        |=> pw_ff == $past(bits[3:0]) && state_ff == ST_WRITE)
        else $error("pulse width not stored");
    transp_drive_a: assert property (
        state_ff == ST_WRITE && pw_ff == 4'h0 && !sclk_rise
        |=> drv_on_ff == !$past(din_i))
        else $error("transparent drive wrong");
    pulse_hold_a: assert property (
        state_ff == ST_WRITE && pw_ff != 4'h0 && pcnt_ff == '0
        && din_rise && !sclk_rise
        |=> !drv_on_ff && pcnt_ff == pulse_len($past(pw_ff)))
        else $error("write pulse not started");
    write_exit_a: assert property (
        state_ff == ST_WRITE && sclk_rise
        |=> state_ff == ST_IDLE && pcnt_ff == '0
        ##1 drv_on_ff == !$past(driver_disable_bit))
        else $error("write mode not ended on clock rise");
    resp_bit_a: assert property (
        state_ff == ST_RESP && sclk_rise && !init_seen && cnt_ff < RESP_BITS
        |=> dout_oe_ff == !$past(resp_ff[7]))
        else $error("answer bit wrong on data-out");
    bad_op_a: assert property (
        state_ff == ST_CMD && sclk_rise && !init_seen
        && cnt_ff == CMD_LAST_BIT && bits[7:6] == 2'h0
        && bits[7:4] != OP_PW_WR_HI && bits != OP_DELAY_RD
        && bits != OP_PHASE_RD && bits[7:2] != OP_PAGE_RD_HI
        |=> state_ff == ST_IDLE)
        else $error("unknown opcode not dropped");
    rx_pass_c: cover property (state_ff == ST_RX_PASS ##1 sclk_rise);
    pulse_c: cover property (pcnt_ff == PULSE_CNT_W'(1) ##2 drv_on_ff);
    answer_c: cover property (state_ff == ST_RESP && cnt_ff == RESP_BITS);

endmodule : rsc_serial_cmd
`default_nettype wire

/* File: design/rsc_pkg.sv */
// Constants, opcodes and state type of the serial command unit
package rsc_pkg;

    // Clock and pulse timing
    localparam int CLK_PERIOD_NS  = 50;
    localparam int PULSE_UNIT_NS  = 8000;
    localparam int PULSE_UNIT_CYC = PULSE_UNIT_NS / CLK_PERIOD_NS;
    localparam int PULSE_CNT_W    = 12;

    // Command framing
    localparam logic [3:0] CMD_LAST_BIT   = 4'h7;
    localparam logic [3:0] SHORT_LAST_BIT = 4'h2;
    localparam logic [3:0] RESP_BITS      = 4'h8;

    // Opcode patterns
    localparam logic [2:0] OP_RX_PASS    = 3'h7;
    localparam logic [2:0] OP_WR_SHORT   = 3'h6;
    localparam logic [3:0] OP_PW_WR_HI   = 4'h1;
    localparam logic [1:0] OP_DELAY_WR   = 2'h2;
    localparam logic [1:0] OP_PAGE_WR    = 2'h1;
    localparam logic [7:0] OP_DELAY_RD   = 8'h02;
    localparam logic [5:0] OP_PAGE_RD_HI = 6'h01;
    localparam logic [7:0] OP_PHASE_RD   = 8'h08;

    // Reset values
    localparam logic [3:0] PAGE0_RST = 4'h8;
    localparam logic [3:0] PAGE_RST  = 4'h0;
    localparam logic [3:0] PW_RST    = 4'h0;
    localparam logic [5:0] DELAY_RST = 6'h00;

    // Page 1 field positions
    localparam int PG1_DRIVER_DISABLE_BIT_BIT = 0;
    localparam int PG1_PD_BIT    = 2;
    localparam int PG1_DEEP_BIT  = 3;

    // Command decoder states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_RESP,
        ST_RX_PASS,
        ST_WRITE
    } rsc_state_t;

endpackage : rsc_pkg

/* File: design/rsc_pin_filter.sv */
// Carrier-rate glitch filter for the serial clock and data-in pins
`timescale 1ns/1ns
`default_nettype none
module rsc_pin_filter
    import rsc_pkg::*;
(
    // Carrier clock and reset
    input  wire logic       car_clk,
    input  wire logic       rst,
    // Raw pins, bit 1 serial clock, bit 0 data-in
    input  wire logic [1:0] pin_raw,
    // Filtered levels
    output logic      [1:0] pin_flt
);

    logic [1:0] s1_ff;
    logic [1:0] s2_ff;
    logic [1:0] prev_ff;
    logic [1:0] out_ff;
    logic [1:0] nxt_out;

    // Two equal successive samples move the filtered level
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            nxt_out[i] = (s2_ff[i] == prev_ff[i]) ? s2_ff[i] : out_ff[i];
        end
    end

    // One sample per carrier period through a two-stage synchroniser
    always_ff @(posedge car_clk or posedge rst) begin
        if (rst) begin
            s1_ff   <= 2'h0;
            s2_ff   <= 2'h0;
            prev_ff <= 2'h0;
            out_ff  <= 2'h0;
        end else begin
            s1_ff   <= pin_raw;
            s2_ff   <= s1_ff;
            prev_ff <= s2_ff;
            out_ff  <= nxt_out;
        end
    end

    assign pin_flt = out_ff;

    flt_agree_a: assert property (@(posedge car_clk) disable iff (rst)
        ((out_ff ^ $past(out_ff)) & ($past(s2_ff) ^ $past(prev_ff))) == 2'h0)
        else $error("filtered level moved without two equal samples");

endmodule : rsc_pin_filter
`default_nettype wire

/* File: bench/rsc_host_model.sv */
// Host controller model driving the serial clock and data-in pins
`timescale 1ns/1ns
`default_nettype none
module rsc_host_model (
    // System clock for pacing
    input  wire logic clk,
    // Host pins
    output logic      sclk_pin,
    output logic      din_pin,
    input  wire logic dout_o,
    input  wire logic dout_oe,
    // Resolved data-out line
    output logic      dout_wire
);
    // Half period of the serial clock in system clocks
    int hp = 6;

    // Open-drain data-out with pull-up
    assign dout_wire = dout_oe ? dout_o : 1'b1;

    // Pins start low so the first init sees a clean rise
    initial begin
        sclk_pin = 1'b0;
        din_pin  = 1'b0;
    end

    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask : w

    // Data-in rises while the serial clock is high
    task automatic init;
        sclk_pin <= 1'b0;
        din_pin  <= 1'b0;
        w(hp);
        sclk_pin <= 1'b1;
        w(hp);
        din_pin <= 1'b1;
        w(hp);
        sclk_pin <= 1'b0;
        w(1);
    endtask : init

    // Top n bits, MSB first, data changed only with clock low
    task automatic send(input logic [7:0] v, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            din_pin <= v[i];
            w(hp);
            sclk_pin <= 1'b1;
            w(hp);
            sclk_pin <= 1'b0;
            w(1);
        end
    endtask : send

    task automatic cmd(input logic [7:0] v);
        init();
        send(v, 8);
    endtask : cmd

    // One serial clock pulse
    task automatic rise;
        sclk_pin <= 1'b1;
        w(hp);
        sclk_pin <= 1'b0;
        w(1);
    endtask : rise

    // Answer bits taken at the end of each high phase
    task automatic read(output logic [7:0] v);
        w(hp);
        for (int i = 7; i >= 0; i--) begin
            sclk_pin <= 1'b1;
            w(hp);
            v[i] = dout_wire;
            sclk_pin <= 1'b0;
            w(hp);
        end
        rise();
    endtask : read
endmodule : rsc_host_model
`default_nettype wire

/* File: bench/rsc_serial_cmd_tb_top.sv */
// Self-checking bench for the serial command unit
`timescale 1ns/1ns
`default_nettype none
module rsc_serial_cmd_tb_top;
    // Bench drive
    logic             clk           = 1'b0;
    logic             car_clk       = 1'b0;
    logic             rst;
    logic             filt_sel;
    logic             rx_data;
    logic [5:0]       phase_val;
    logic [3:0]       status_nibble;
    // Design outputs and pins
    wire logic        sclk_pin;
    wire logic        din_pin;
    wire logic        dout_o;
    wire logic        dout_oe;
    wire logic        dout_wire;
    wire logic        drv_on;
    wire logic [3:0]  pulse_width;
    wire logic [5:0]  sample_delay;
    wire logic [3:0]  cfg_page0;
    wire logic [3:0]  cfg_page1;
    wire logic [3:0]  cfg_page2;
    wire logic [3:0]  cfg_page3;
    wire logic [15:0] pages = {cfg_page3, cfg_page2, cfg_page1, cfg_page0};
    logic [7:0]       rd;
    logic [3:0]       pval [4] = '{4'h3, 4'h2, 4'hA, 4'hC};
    int               err_count = 0;
    int               n_tests   = 0;

    // System and carrier clocks
    always #25 clk = ~clk;
    always #16 car_clk = ~car_clk;

    rsc_serial_cmd u_dut (
        .clk(clk), .rst(rst), .car_clk(car_clk), .sclk_pin(sclk_pin),
        .din_pin(din_pin), .dout_o(dout_o), .dout_oe(dout_oe),
        .filt_sel(filt_sel), .rx_data(rx_data), .phase_val(phase_val),
        .status_nibble(status_nibble), .drv_on(drv_on),
        .pulse_width(pulse_width), .sample_delay(sample_delay),
        .cfg_page0(cfg_page0), .cfg_page1(cfg_page1),
        .cfg_page2(cfg_page2), .cfg_page3(cfg_page3)
    );

    rsc_host_model u_host (
        .clk(clk), .sclk_pin(sclk_pin), .din_pin(din_pin),
        .dout_o(dout_o), .dout_oe(dout_oe), .dout_wire(dout_wire)
    );

    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask : w

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic chk1(input logic seen, input logic exp);
        check({7'h00, seen}, {7'h00, exp});
    endtask : chk1

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    // Timed off pulse of n units, data-in dropped early
    task automatic pulse(input int n);
        u_host.din_pin <= 1'b0;
        w(6);
        chk1(drv_on, 1'b1);
        u_host.din_pin <= 1'b1;
        w(10);
        chk1(drv_on, 1'b0);
        u_host.din_pin <= 1'b0;
        w(n * 160 - 30);
        chk1(drv_on, 1'b0);
        w(40);
        chk1(drv_on, 1'b1);
    endtask : pulse

    // Main test sequence
    initial begin
        rst           <= 1'b1;
        filt_sel      <= 1'b0;
        rx_data       <= 1'b0;
        phase_val     <= 6'h00;
        status_nibble <= 4'h5;
        w(5);
        rst <= 1'b0;
        w(10);
        check({4'h0, pulse_width}, 8'h00);
        // Short write with no earlier width: transparent drive
        u_host.init();
        u_host.send(8'hC0, 3);
        w(4);
        chk1(drv_on, 1'b1);
        u_host.din_pin <= 1'b1;
        w(6);
        chk1(drv_on, 1'b0);
        u_host.din_pin <= 1'b0;
        w(6);
        chk1(drv_on, 1'b1);
        u_host.rise();
        $display("test short write default done");
        // Timed write, then short write reusing the width
        u_host.cmd(8'h11);
        check({4'h0, pulse_width}, 8'h01);
        w(4);
        pulse(1);
        u_host.rise();
        u_host.init();
        u_host.send(8'hC0, 3);
        w(4);
        pulse(1);
        u_host.rise();
        // Longest width, then a pulse cut short by the serial clock
        u_host.cmd(8'h1F);
        w(4);
        pulse(15);
        u_host.din_pin <= 1'b1;
        w(100);
        chk1(drv_on, 1'b0);
        u_host.rise();
        chk1(drv_on, 1'b1);
        $display("test write modes done");
        // Phase query and sampling delay
        phase_val <= 6'h2D;
        u_host.cmd(8'h08);
        u_host.read(rd);
        check(rd, 8'h2D);
        chk1(dout_oe, 1'b0);
        u_host.cmd(8'hB5);
        check({2'b00, sample_delay}, 8'h35);
        u_host.cmd(8'h02);
        u_host.read(rd);
        check(rd, 8'h35);
        $display("test phase and delay done");
        // Every configuration page written and read back
        for (int p = 0; p < 4; p++) begin
            status_nibble <= ~pval[p];
            u_host.cmd({2'b01, p[1:0], pval[p]});
            check({4'h0, pages[p*4 +: 4]}, {4'h0, pval[p]});
            u_host.cmd({6'h01, p[1:0]});
            u_host.read(rd);
            check(rd, {(p < 2) ? 4'hF : ~pval[p], pval[p]});
        end
        $display("test pages done");
        // Receive passthrough follows rx data until a clock rise
        u_host.init();
        u_host.send(8'hE0, 3);
        rx_data <= 1'b1;
        w(4);
        chk1(dout_wire, 1'b1);
        rx_data <= 1'b0;
        w(4);
        chk1(dout_wire, 1'b0);
        u_host.rise();
        chk1(dout_oe, 1'b0);
        $display("test passthrough done");
        // Unknown opcode, then an aborted command restarted by init
        u_host.cmd(8'h03);
        u_host.read(rd);
        check(rd, 8'hFF);
        u_host.init();
        u_host.send(8'h08, 4);
        u_host.cmd(8'h08);
        u_host.read(rd);
        check(rd, 8'h2D);
        $display("test unknown and restart done");
        // Filtered pins, deep sleep and wake
        filt_sel <= 1'b1;
        u_host.hp = 16;
        w(20);
        u_host.cmd(8'h08);
        u_host.read(rd);
        check(rd, 8'h2D);
        u_host.cmd(8'h5D);
        check({4'h0, cfg_page1}, 8'h0D);
        u_host.din_pin <= 1'b0;
        w(10);
        check({4'h0, cfg_page1}, 8'h05);
        u_host.cmd(8'h50);
        chk1(drv_on, 1'b1);
        $display("test filtered done");
        summarize();
    end

    // Watchdog well beyond the roughly 7200 cycles the tests take
    initial begin
        w(60000);
        err_count++;
        summarize();
    end
endmodule : rsc_serial_cmd_tb_top
`default_nettype wire
